// [hw/rst_seq_pkg.sv]
// Package of constants and types for the reset, boot and password sequencer.
package rst_seq_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int OSC_STARTUP_US = 1000;
	localparam int OSC_STARTUP_CYC = (OSC_STARTUP_US * (CLK_HZ / 1_000_000) > 0) ?
		OSC_STARTUP_US * (CLK_HZ / 1_000_000) : 1;
	localparam int WAIT_W = 16;

	// ****************************************
	// Addresses and field positions
	// ****************************************
	localparam logic [15:0] BOOT_ROM_ADDR = 16'h8000;
	localparam logic [15:0] APP_START_ADDR = 16'h0000;
	localparam logic [15:0] PW_FIRST_ADDR = 16'h0010;
	localparam logic [15:0] PW_LAST_ADDR = 16'h001F;
	localparam int PW_WORDS = 16;
	localparam int PW_IDX_W = 4;
	localparam int POR_FLAG_BIT = 7;
	localparam logic [15:0] WORD_ONES = 16'hFFFF;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [7:0] BYTE_ONES = 8'hFF;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic LOCK_RESET_VAL = 1'b1;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		ST_BROWNOUT = 2'b00,
		ST_STARTUP = 2'b01,
		ST_RUN = 2'b10
	} seq_state_e;

	typedef enum logic [1:0] {
		PW_IDLE = 2'b00,
		PW_SCAN = 2'b01,
		PW_DONE = 2'b10
	} pw_state_e;

	typedef struct packed {
		logic core_rst;
		logic clk_en;
		logic por_flag;
		logic [15:0] fetch_addr;
		logic pins_hiz;
		logic pullup_en;
	} boot_out_s;

	// Check of one password word against the blank patterns.
	function automatic logic [1:0] word_blank(input logic [15:0] w);
		word_blank = {w == WORD_ONES, w == WORD_ZERO};
	endfunction : word_blank

endpackage : rst_seq_pkg

// [hw/brownout_sync.sv]
// Two-stage synchroniser for the brownout comparator level.
`timescale 1ns/1ps
module brownout_sync
	import rst_seq_pkg::*;
(
	input wire logic ref_clk_in, // Instruction clock.
	input wire logic async_in, // Raw level from outside the clock domain.
	output logic sync_out // Level after two flip-flops.
);
	typedef struct packed {
		logic s1;
		logic s2;
	} sync_s;

	sync_s st_r;
	sync_s st_nxt;

	always_comb begin
		st_nxt.s1 = async_in;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge ref_clk_in) begin
		st_r <= st_nxt;
	end

	assign sync_out = st_r.s2;
endmodule : brownout_sync

// [hw/pw_word_mem.sv]
// Sixteen-word password store with registered read data.
`timescale 1ns/1ps
module pw_word_mem
	import rst_seq_pkg::*;
#(
	parameter int DEPTH = PW_WORDS,
	parameter int AW = PW_IDX_W
)(
	input wire logic ref_clk_in, // Clock.
	input wire logic wr_en_in, // Write one word.
	input wire logic erase_in, // Mass erase to all ones.
	input wire logic [AW-1:0] wr_idx_in, // Write index.
	input wire logic [15:0] wr_data_in, // Write data.
	input wire logic [AW-1:0] rd_idx_in, // Read index.
	output logic [15:0] rd_data_out // Registered read data.
);
	logic [15:0] mem_r [DEPTH];
	logic [15:0] rd_r;

	always_ff @(posedge ref_clk_in) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (erase_in) begin
				mem_r[i] <= WORD_ONES;
			end else if (wr_en_in && wr_idx_in == AW'(i)) begin
				mem_r[i] <= wr_data_in;
			end
		end
		rd_r <= mem_r[rd_idx_in];
	end

	assign rd_data_out = rd_r;
endmodule : pw_word_mem

// [hw/reset_boot_password_seq.sv]
// Power-up, brownout reset, boot vector and password gate sequencer.
`timescale 1ns/1ps

module reset_boot_password_seq
	import rst_seq_pkg::*;
#(
	parameter int STARTUP_CYC = OSC_STARTUP_CYC
)(
	input wire logic ref_clk_in, // Ring-oscillator instruction clock.
	input wire logic srst_in, // Synchronous reset, active high.
	input wire logic brownout_in, // Comparator: supply below threshold.
	input wire logic lock_clear_in, // Core clears the password-lock bit.
	input wire logic pw_wr_in, // Write one password word.
	input wire logic mass_erase_in, // Program memory mass erase.
	input wire logic [15:0] pw_wr_addr_in, // Program address of the word.
	input wire logic [15:0] pw_wr_data_in, // Word written.
	input wire logic pw_try_in, // Level: start a password compare, held until the scan ends.
	input wire logic [15:0] pw_try_word_in, // Supplied word for current index.
	input wire logic boot_done_in, // Utility ROM chooses application start.
	input wire logic por_flag_clr_in, // Software clears the power-on flag.
	output logic core_rst_out, // Core and peripheral reset, active high.
	output logic clk_en_out, // Instruction clock gate enable.
	output logic por_flag_out, // Watchdog control register bit 7.
	output logic [15:0] fetch_addr_out, // Fetch address vector.
	output logic pins_hiz_out, // Input and open-drain pins undriven.
	output logic pullup_en_out, // Weak pull-ups on port pins.
	output logic lock_bit_out, // Password-lock bit.
	output logic util_grant_out, // Utility debug and programming allowed.
	output logic [PW_IDX_W-1:0] pw_idx_out // Word index the supplied word is for.
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		seq_state_e seq;
		logic [WAIT_W-1:0] wait_cnt;
		boot_out_s o;
		logic lock;
		pw_state_e pw;
		logic [PW_IDX_W-1:0] idx;
		logic all_ones;
		logic all_zero;
		logic match;
		logic unlocked;
		logic grant;
		logic chk_pend;
	} seq_s;

	seq_s st_r;
	seq_s st_nxt;
	logic bo_sync;
	logic [15:0] mem_rd;
	logic [PW_IDX_W-1:0] wr_idx;
	logic wr_hit;
	logic [1:0] blank;

	// ****************************************
	// Brownout input crossing
	// ****************************************
	brownout_sync u_bo_sync (
		.ref_clk_in(ref_clk_in),
		.async_in(brownout_in),
		.sync_out(bo_sync)
	);

	// ****************************************
	// Password words
	// ****************************************
	assign wr_hit = pw_wr_in && pw_wr_addr_in >= PW_FIRST_ADDR
		&& pw_wr_addr_in <= PW_LAST_ADDR;
	assign wr_idx = pw_wr_addr_in[PW_IDX_W-1:0];

	pw_word_mem #(
		.DEPTH(PW_WORDS),
		.AW(PW_IDX_W)
	) u_pw_mem (
		.ref_clk_in(ref_clk_in),
		.wr_en_in(wr_hit),
		.erase_in(mass_erase_in),
		.wr_idx_in(wr_idx),
		.wr_data_in(pw_wr_data_in),
		.rd_idx_in(st_r.idx),
		.rd_data_out(mem_rd)
	);

	assign blank = word_blank(mem_rd);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_nxt = st_r;
		case (st_r.seq)
			ST_BROWNOUT: begin
				st_nxt.o.core_rst = 1'b1;
				st_nxt.o.clk_en = 1'b0;
				st_nxt.o.por_flag = 1'b1;
				st_nxt.o.fetch_addr = BOOT_ROM_ADDR;
				st_nxt.o.pins_hiz = 1'b1;
				st_nxt.o.pullup_en = 1'b1;
				st_nxt.lock = LOCK_RESET_VAL;
				st_nxt.unlocked = 1'b0;
				st_nxt.wait_cnt = '0;
				if (!bo_sync) begin
					st_nxt.seq = ST_STARTUP;
				end
			end
			ST_STARTUP: begin
				if (bo_sync) begin
					st_nxt.seq = ST_BROWNOUT;
				end else if (st_r.wait_cnt == WAIT_W'(STARTUP_CYC - 1)) begin
					st_nxt.seq = ST_RUN;
					st_nxt.o.core_rst = 1'b0;
					st_nxt.o.clk_en = 1'b1;
				end else begin
					st_nxt.wait_cnt = st_r.wait_cnt + 1'b1;
				end
			end
			ST_RUN: begin
				if (bo_sync) begin
					st_nxt.seq = ST_BROWNOUT;
					st_nxt.o.core_rst = 1'b1;
					st_nxt.o.clk_en = 1'b0;
				end else begin
					if (boot_done_in && st_r.o.pins_hiz) begin
						st_nxt.o.fetch_addr = APP_START_ADDR;
						st_nxt.o.pins_hiz = 1'b0;
					end
					if (por_flag_clr_in) begin
						st_nxt.o.por_flag = 1'b0;
					end
					if (lock_clear_in) begin
						st_nxt.lock = 1'b0;
					end
				end
			end
			default: begin
				st_nxt.seq = ST_BROWNOUT;
			end
		endcase

		// Scan of the password words: blank check and supplied-word compare.
		case (st_r.pw)
			PW_IDLE: begin
				if (st_r.chk_pend || pw_try_in || wr_hit || mass_erase_in) begin
					st_nxt.pw = PW_SCAN;
					st_nxt.idx = '0;
					st_nxt.all_ones = 1'b1;
					st_nxt.all_zero = 1'b1;
					st_nxt.match = 1'b1;
					st_nxt.chk_pend = 1'b0;
				end
			end
			PW_SCAN: begin
				st_nxt.pw = PW_DONE;
			end
			PW_DONE: begin
				st_nxt.all_ones = st_r.all_ones & blank[1];
				st_nxt.all_zero = st_r.all_zero & blank[0];
				st_nxt.match = st_r.match & (mem_rd == pw_try_word_in);
				if (st_r.idx == PW_IDX_W'(PW_WORDS - 1)) begin
					st_nxt.pw = PW_IDLE;
					if (pw_try_in && st_r.match && mem_rd == pw_try_word_in) begin
						st_nxt.unlocked = 1'b1;
					end
				end else begin
					st_nxt.idx = st_r.idx + 1'b1;
					st_nxt.pw = PW_SCAN;
				end
			end
			default: begin
				st_nxt.pw = PW_IDLE;
			end
		endcase
		if (st_r.pw != PW_IDLE && (wr_hit || mass_erase_in)) begin
			st_nxt.chk_pend = 1'b1;
		end

		st_nxt.grant = !st_r.lock || st_r.all_ones || st_r.all_zero
			|| st_r.unlocked;
		// Grant drops on the same edge as reset rises, so no cycle shows both.
		if (st_nxt.o.core_rst) begin
			st_nxt.grant = 1'b0;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			st_r <= '0;
			st_r.seq <= ST_BROWNOUT;
			st_r.o.core_rst <= 1'b1;
			st_r.o.por_flag <= 1'b1;
			st_r.o.fetch_addr <= BOOT_ROM_ADDR;
			st_r.o.pins_hiz <= 1'b1;
			st_r.o.pullup_en <= 1'b1;
			st_r.lock <= LOCK_RESET_VAL;
			st_r.pw <= PW_IDLE;
			st_r.chk_pend <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign core_rst_out = st_r.o.core_rst;
	assign clk_en_out = st_r.o.clk_en;
	assign por_flag_out = st_r.o.por_flag;
	assign fetch_addr_out = st_r.o.fetch_addr;
	assign pins_hiz_out = st_r.o.pins_hiz;
	assign pullup_en_out = st_r.o.pullup_en;
	assign lock_bit_out = st_r.lock;
	assign util_grant_out = st_r.grant;
	assign pw_idx_out = st_r.idx;
endmodule : reset_boot_password_seq

// [tb/rst_seq_sva.sv]
// Assertion checker for the reset, boot and password sequencer.
`timescale 1ns/1ps
module rst_seq_sva
	import rst_seq_pkg::*;
#(
	parameter int STARTUP_CYC = OSC_STARTUP_CYC
)(
	input wire logic ref_clk_in, // Clock.
	input wire logic srst_in, // Reset.
	input wire logic brownout_in, // Low supply.
	input wire logic lock_clear_in, // Unlock.
	input wire logic boot_done_in, // ROM done.
	input wire logic core_rst_out, // Core reset.
	input wire logic clk_en_out, // Clock gate.
	input wire logic por_flag_out, // Power-on flag.
	input wire logic [15:0] fetch_addr_out, // Fetch vector.
	input wire logic pins_hiz_out, // Pins undriven.
	input wire logic pullup_en_out, // Pull-ups.
	input wire logic lock_bit_out, // Lock bit.
	input wire logic util_grant_out // Grant.
);
	// ****************************************
	// Supply-good age counter
	// ****************************************
	logic [15:0] low_cnt_r;
	always_ff @(posedge ref_clk_in) begin
		if (srst_in || brownout_in) begin
			low_cnt_r <= 16'h0000;
		end else if (low_cnt_r != 16'hFFFF) begin
			low_cnt_r <= low_cnt_r + 16'h0001;
		end
	end
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (srst_in);
	AST_BO_RST: assert property (brownout_in |-> ##[0:3] core_rst_out)
		else $error("reset missing under brownout");
	AST_RUN_BO: assert property (brownout_in [*4] |=> core_rst_out)
		else $error("reset dropped while brownout held");
	AST_WAIT_MIN: assert property ($fell(core_rst_out) |-> low_cnt_r >= STARTUP_CYC)
		else $error("reset released before startup wait");
	AST_WAIT_MAX: assert property (low_cnt_r == STARTUP_CYC + 8 |-> !core_rst_out)
		else $error("reset held past startup wait");
	AST_CLK_GATE: assert property ($fell(core_rst_out) |-> $rose(clk_en_out))
		else $error("clock enable not aligned with reset release");
	AST_VEC: assert property ($fell(core_rst_out) |-> fetch_addr_out == 16'h8000 && pins_hiz_out)
		else $error("wrong vector at reset release");
	AST_RST_VALS: assert property (disable iff (1'b0) srst_in |=>
		core_rst_out && !clk_en_out && por_flag_out && lock_bit_out && !util_grant_out)
		else $error("wrong values after reset");
	AST_BOOT: assert property (boot_done_in && !core_rst_out |->
		##[1:3] (fetch_addr_out == 16'h0000 && !pins_hiz_out))
		else $error("no jump to application");
	AST_UNLOCK: assert property (lock_clear_in && !core_rst_out |-> ##[1:3] !lock_bit_out)
		else $error("lock bit not cleared");
	AST_GRANT_RST: assert property (core_rst_out |-> !util_grant_out)
		else $error("grant during reset");
	AST_PULLUP: assert property (pullup_en_out)
		else $error("pull-ups off");
endmodule : rst_seq_sva
bind reset_boot_password_seq rst_seq_sva #(.STARTUP_CYC(STARTUP_CYC)) u_sva (.ref_clk_in,
	.srst_in, .brownout_in, .lock_clear_in, .boot_done_in, .core_rst_out, .clk_en_out,
	.por_flag_out, .fetch_addr_out, .pins_hiz_out, .pullup_en_out, .lock_bit_out,
	.util_grant_out);

// [tb/core_model.sv]
// Core-side model that leaves the utility ROM a few cycles after reset release.
`timescale 1ns/1ps
module core_model (
	input wire logic ref_clk_in, // Clock.
	input wire logic core_rst_in, // Reset from the sequencer.
	input wire logic [15:0] fetch_addr_in, // Fetch vector.
	output logic boot_done_out // Utility ROM finished.
);
	int cnt;
	initial begin
		boot_done_out = 1'b0;
		cnt = 0;
	end
	// The utility ROM runs four cycles, then pulses once to start the application.
	always @(negedge ref_clk_in) begin
		if (core_rst_in) begin
			cnt = 0;
			boot_done_out <= 1'b0;
		end else if (fetch_addr_in === 16'h8000 && cnt < 4) begin
			cnt = cnt + 1;
			boot_done_out <= (cnt == 4);
		end else begin
			boot_done_out <= 1'b0;
		end
	end
endmodule : core_model

// [tb/testbench.sv]
// Self-checking testbench for the reset, boot and password sequencer.
`timescale 1ns/1ps
module testbench;
	import rst_seq_pkg::*;
	localparam int SCYC = 20;
	logic ref_clk_in, srst_in, brownout_in, lock_clear_in, pw_wr_in, mass_erase_in;
	logic pw_try_in, boot_done_in, por_flag_clr_in, core_rst_out, clk_en_out, por_flag_out;
	logic pins_hiz_out, pullup_en_out, lock_bit_out, util_grant_out;
	logic [15:0] pw_wr_addr_in, pw_wr_data_in, pw_try_word_in, fetch_addr_out;
	logic [PW_IDX_W-1:0] pw_idx_out;
	int error_cnt, checks_done;
	reset_boot_password_seq #(.STARTUP_CYC(SCYC)) DUT (.*);
	core_model u_core (.ref_clk_in, .core_rst_in(core_rst_out), .fetch_addr_in(fetch_addr_out),
		.boot_done_out(boot_done_in));
	initial begin
		ref_clk_in = 1'b0;
		forever #50 ref_clk_in = ~ref_clk_in;
	end
	// Supplied password: zero words, last word 1234h.
	always @(negedge ref_clk_in) pw_try_word_in <= (pw_idx_out == 4'hF) ? 16'h1234 : 16'h0000;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_rel(output int cyc);
		cyc = 0;
		while (core_rst_out !== 1'b0 && cyc < 200) begin
			@(negedge ref_clk_in);
			cyc++;
		end
		chk(16'(cyc > SCYC && cyc <= SCYC + 8), 16'h0001);
	endtask : wait_rel
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		pw_wr_addr_in = a;
		pw_wr_data_in = d;
		pw_wr_in = 1'b1;
		@(negedge ref_clk_in);
		pw_wr_in = 1'b0;
		repeat (48) @(negedge ref_clk_in);
	endtask : wr
	task automatic t_powerup();
		int c;
		repeat (5) @(negedge ref_clk_in);
		chk({core_rst_out, lock_bit_out, util_grant_out}, 16'h0006);
		brownout_in = 1'b0;
		wait_rel(c);
		chk({clk_en_out, por_flag_out, pins_hiz_out, pullup_en_out}, 16'h000F);
		chk(fetch_addr_out, 16'h8000);
		repeat (8) @(negedge ref_clk_in);
		chk({fetch_addr_out[14:0], pins_hiz_out}, 16'h0000);
	endtask : t_powerup
	task automatic t_password();
		mass_erase_in = 1'b1;
		@(negedge ref_clk_in);
		mass_erase_in = 1'b0;
		repeat (48) @(negedge ref_clk_in);
		chk(16'(util_grant_out), 16'h0001);
		wr(16'h0020, 16'h1234);
		chk(16'(util_grant_out), 16'h0001);
		wr(16'h001F, 16'h1234);
		chk(16'(util_grant_out), 16'h0000);
		for (int i = 0; i < 16; i++) wr(16'h0010 + 16'(i), 16'h0000);
		chk(16'(util_grant_out), 16'h0001);
		wr(16'h001F, 16'h1234);
		chk(16'(util_grant_out), 16'h0000);
		pw_try_in = 1'b1;
		repeat (48) @(negedge ref_clk_in);
		pw_try_in = 1'b0;
		chk(16'(util_grant_out), 16'h0001);
		lock_clear_in = 1'b1;
		por_flag_clr_in = 1'b1;
		@(negedge ref_clk_in);
		lock_clear_in = 1'b0;
		por_flag_clr_in = 1'b0;
		repeat (4) @(negedge ref_clk_in);
		chk({lock_bit_out, por_flag_out, util_grant_out}, 16'h0001);
	endtask : t_password
	task automatic t_abort();
		int c;
		brownout_in = 1'b1;
		repeat (5) @(negedge ref_clk_in);
		chk({core_rst_out, clk_en_out, util_grant_out}, 16'h0004);
		chk(fetch_addr_out, 16'h8000);
		chk({lock_bit_out, por_flag_out, pins_hiz_out}, 16'h0007);
		brownout_in = 1'b0;
		repeat (10) @(negedge ref_clk_in);
		chk(16'(core_rst_out), 16'h0001);
		brownout_in = 1'b1;
		repeat (3) @(negedge ref_clk_in);
		brownout_in = 1'b0;
		wait_rel(c);
		repeat (8) @(negedge ref_clk_in);
	endtask : t_abort
	task automatic summarize();
		if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize
	initial begin
		#(5000 * 100);
		error_cnt++;
		summarize();
	end
	initial begin
		{srst_in, brownout_in} = 2'b11;
		{lock_clear_in, pw_wr_in, mass_erase_in, pw_try_in, por_flag_clr_in} = 5'h00;
		{pw_wr_addr_in, pw_wr_data_in} = 32'h0;
		error_cnt = 0;
		checks_done = 0;
		repeat (6) @(negedge ref_clk_in);
		srst_in = 1'b0;
		t_powerup();
		t_password();
		t_abort();
		summarize();
	end
endmodule : testbench
